// ==== core/gcu_core.sv ====
// Gauge trim, report correction, offset calibration and register slave
`timescale 1ns/100ps
`default_nettype none
module gcu_core
  import gcu_pkg::*;
#(
  parameter int unsigned   CAL_LEN = CAL_CYCLES,     // Calibration length
  parameter int unsigned   CAL_GAP = CAL_GAP_CYCLES, // Sleep time per run
  parameter logic [31:0]   KEY     = UNLOCK_KEY_RST  // Unlock key
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address and data
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Raw measurements from the front end
  input  wire logic        meas_valid,
  input  wire gcu_meas_s   meas,
  // Corrected reports and status
  output logic             report_valid,
  output logic [15:0]      average_current_report,
  output logic [15:0]      temp_report,
  output logic [15:0]      volt_report,
  output logic             offset_cal_active,
  output logic             sleep_active,
  output logic             sealed
);
  // Bus state
  logic        aw_held, w_held;        // Captured address and data
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        next_aw_held, next_w_held, next_bvalid, next_rvalid;
  logic [7:0]  next_aw_addr;
  logic [31:0] next_w_data, next_rdata;
  logic [3:0]  next_w_strb;
  logic [1:0]  next_bresp, next_rresp;
  logic        wr_fire;                // Write performed this cycle
  // Software registers
  logic        sleep_feature_enable, cal_mode;
  gcu_trim_s   trim, next_trim;
  logic [15:0] counter_gain_factor, next_gain;
  logic [19:0] counter_timebase_constant, next_delta;
  logic        next_sleep_en, next_cal_mode;
  logic        seal_req, cmd_valid;    // Pulses into the key checker
  logic [31:0] wmerged;                // Write data merged by strobes
  // Datapath
  logic signed [17:0] cc_fix;          // Offset-corrected counter value
  logic signed [34:0] cc_prod;
  logic signed [19:0] cc_scaled;
  logic signed [20:0] delta_dev;
  logic signed [41:0] tb_prod;
  logic signed [20:0] cur_wide;
  logic        [20:0] cur_mag;
  logic        [15:0] next_cur, next_temp, next_volt;
  logic               next_sleep;
  // Calibration
  gcu_cal_e           cal_state, next_cal_state;
  logic        [31:0] cal_timer, next_cal_timer;
  logic signed [19:0] cal_acc, next_cal_acc;
  logic        [15:0] counter_offset_trim, next_cofs;

  // Merge one register with the strobed write bytes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = data[8*i +: 8];
      end
    end
    return res;
  endfunction

  // Read mux; unmapped offsets answer with a slave error
  function automatic logic [32:0] rd_mux(input logic [7:0] a);
    logic [31:0] d;
    logic        ok;
    d  = 32'h0000_0000;
    ok = 1'b1;
    unique case ({a[7:2], 2'b00})
      ADDR_CTRL:  d = {29'h0, 1'b0, cal_mode, sleep_feature_enable};
      ADDR_STAT:  d = {29'h0, sleep_active, offset_cal_active, sealed};
      ADDR_CMD:   d = 32'h0000_0000;
      ADDR_TRIM:  d = trim;
      ADDR_GAIN:  d = {16'h0000, counter_gain_factor};
      ADDR_DELTA: d = {12'h000, counter_timebase_constant};
      ADDR_COFS:  d = {16'h0000, counter_offset_trim};
      ADDR_CUR:   d = {16'h0000, average_current_report};
      ADDR_TEMP:  d = {16'h0000, temp_report};
      ADDR_VOLT:  d = {16'h0000, volt_report};
      default:    ok = 1'b0;
    endcase
    return {ok, d};
  endfunction

  // Bus handshakes: address and data taken in any order, one write at once
  always_comb begin
    logic [32:0] rd;
    logic [32:0] wr_chk;               // Decode of the held write address
    rd           = rd_mux(s_axi_araddr);
    wr_chk       = rd_mux(aw_addr);
    wr_fire      = aw_held && w_held && !s_axi_bvalid;
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_rvalid  = s_axi_rvalid;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (wr_fire) begin
      // Release both holds and answer in the same edge
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = wr_chk[32] ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rdata  = rd[31:0];
      next_rresp  = rd[32] ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  // Bus registers; write ready flags are registered copies of free holds, read ready of no pending rvalid
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      aw_addr       <= 8'h00;
      w_held        <= 1'b0;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      aw_held       <= next_aw_held;
      aw_addr       <= next_aw_addr;
      w_held        <= next_w_held;
      w_data        <= next_w_data;
      w_strb        <= next_w_strb;
      s_axi_awready <= !next_aw_held;
      s_axi_wready  <= !next_w_held;
      s_axi_arready <= !next_rvalid;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
    end
  end

  // Register writes; trims are frozen while the gauge is sealed
  always_comb begin
    wmerged       = merge(32'h0000_0000, w_data, w_strb);
    next_sleep_en = sleep_feature_enable;
    next_cal_mode = cal_mode;
    next_trim     = trim;
    next_gain     = counter_gain_factor;
    next_delta    = counter_timebase_constant;
    seal_req      = 1'b0;
    cmd_valid     = 1'b0;
    if (wr_fire) begin
      unique case ({aw_addr[7:2], 2'b00})
        ADDR_CTRL: begin
          if (w_strb[0]) begin
            next_sleep_en = w_data[CTRL_SLEEP];
            next_cal_mode = w_data[CTRL_CAL] && !sealed;
            seal_req      = w_data[CTRL_SEAL];
          end
        end
        // Every write here is a command word, key or not
        ADDR_CMD: cmd_valid = 1'b1;
        ADDR_TRIM: begin
          if (!sealed) begin
            next_trim = merge(trim, w_data, w_strb);
            // Voltage offset only moves in calibration mode
            if (!cal_mode) begin
              next_trim.pack_v = trim.pack_v;
            end
          end
        end
        ADDR_GAIN: begin
          if (!sealed) begin
            next_gain = 16'(merge({16'h0000, counter_gain_factor},
                                  w_data, w_strb));
          end
        end
        ADDR_DELTA: begin
          if (!sealed) begin
            next_delta = 20'(merge({12'h000, counter_timebase_constant},
                                   w_data, w_strb));
          end
        end
        default: begin
          // Read-only and unmapped writes change nothing
        end
      endcase
    end
  end

  // Software register storage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sleep_feature_enable      <= 1'b0;
      cal_mode                  <= 1'b0;
      trim                      <= TRIM_RST;
      counter_gain_factor       <= GAIN_RST;
      counter_timebase_constant <= DELTA_RST;
    end else begin
      sleep_feature_enable      <= next_sleep_en;
      cal_mode                  <= next_cal_mode;
      trim                      <= next_trim;
      counter_gain_factor       <= next_gain;
      counter_timebase_constant <= next_delta;
    end
  end

  // Key sequence and sealed flag
  gcu_key_check #(
    .KEY       (KEY)
  ) u_key (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .cmd_valid (cmd_valid),
    .cmd_word  (wmerged[15:0]),
    .seal_req  (seal_req),
    .sealed    (sealed)
  );

  // Current path: offsets, gain, time-base, then deadband
  always_comb begin
    cc_fix    = 18'(meas.cc) - 18'(signed'(counter_offset_trim))
              + 18'(trim.board);
    cc_prod   = cc_fix * signed'({1'b0, counter_gain_factor});
    cc_scaled = 20'(cc_prod >>> GAIN_FRAC);
    delta_dev = signed'({1'b0, counter_timebase_constant})
              - signed'({1'b0, DELTA_RST});
    tb_prod   = cc_scaled * delta_dev;
    cur_wide  = 21'(cc_scaled) + 21'(tb_prod >>> DELTA_SHIFT);
    cur_mag   = cur_wide[20] ? 21'(-cur_wide) : cur_wide;
    // Saturate so a large reading never wraps its sign
    if (cur_wide > 21'sd32767) begin
      next_cur = 16'h7FFF;
    end else if (cur_wide < -21'sd32768) begin
      next_cur = 16'h8000;
    end else begin
      next_cur = cur_wide[15:0];
    end
    if (cur_mag < 21'(trim.deadband)) begin
      next_cur = 16'h0000;
    end
    next_temp  = meas.temp + 16'(trim.temp);
    next_volt  = meas.volt + 16'(trim.pack_v);
    next_sleep = sleep_feature_enable
              && cur_mag < 21'(SLEEP_MA);
  end

  // Report registers, updated once per measurement
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      report_valid           <= 1'b0;
      average_current_report <= 16'h0000;
      temp_report            <= 16'h0000;
      volt_report            <= 16'h0000;
      sleep_active           <= 1'b0;
    end else begin
      report_valid <= meas_valid;
      if (meas_valid) begin
        average_current_report <= next_cur;
        temp_report            <= next_temp;
        volt_report            <= next_volt;
      end
      // Clearing the enable wakes at once, no measurement needed
      if (!sleep_feature_enable) begin
        sleep_active <= 1'b0;
      end else if (meas_valid) begin
        sleep_active <= next_sleep;
      end
    end
  end

  // Offset calibration: wait in sleep, then integrate for the full time
  always_comb begin
    next_cal_state = cal_state;
    next_cal_timer = cal_timer;
    next_cal_acc   = cal_acc;
    next_cofs      = counter_offset_trim;
    unique case (cal_state)
      CAL_WAIT: begin
        next_cal_timer = sleep_active ? cal_timer + 32'h1 : 32'h0;
        if (sleep_active && cal_timer == CAL_GAP - 1) begin
          next_cal_state = CAL_RUN;
          next_cal_timer = 32'h0;
          next_cal_acc   = 20'sh00000;
        end
      end
      CAL_RUN: begin
        next_cal_timer = cal_timer + 32'h1;
        // Running average of raw counter samples
        if (meas_valid) begin
          next_cal_acc = cal_acc + 20'(meas.cc)
                       - (cal_acc >>> CAL_AVG_SHIFT);
        end
        if (!sleep_active) begin
          // Woken early: abandon, keep the old offset
          next_cal_state = CAL_WAIT;
          next_cal_timer = 32'h0;
        end else if (cal_timer == CAL_LEN - 1) begin
          next_cal_state = CAL_WAIT;
          next_cal_timer = 32'h0;
          next_cofs      = 16'(cal_acc >>> CAL_AVG_SHIFT);
        end
      end
    endcase
  end

  // Calibration registers; the active bit tracks the run state exactly
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cal_state           <= CAL_WAIT;
      cal_timer           <= 32'h0;
      cal_acc             <= 20'sh00000;
      counter_offset_trim <= 16'h0000;
      offset_cal_active   <= 1'b0;
    end else begin
      cal_state           <= next_cal_state;
      cal_timer           <= next_cal_timer;
      cal_acc             <= next_cal_acc;
      counter_offset_trim <= next_cofs;
      offset_cal_active   <= next_cal_state == CAL_RUN;
    end
  end

  deadband_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    meas_valid && cur_mag < 21'(trim.deadband)
      |=> report_valid && average_current_report == 16'h0000)
    else $error("current inside deadband not reported as zero");
  temp_trim_a: assert property (@(posedge aclk) disable iff (!aresetn)
    meas_valid |=> temp_report == $past(meas.temp) + 16'($past(trim.temp)))
    else $error("temperature not offset by trim");
  volt_trim_a: assert property (@(posedge aclk) disable iff (!aresetn)
    meas_valid |=> volt_report == $past(meas.volt) + 16'($past(trim.pack_v)))
    else $error("voltage not offset by trim");
  pack_lock_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(trim.pack_v) |-> $past(cal_mode) && !$past(sealed))
    else $error("voltage offset changed outside calibration mode");
  cal_state_a: assert property (@(posedge aclk) disable iff (!aresetn)
    offset_cal_active |-> cal_state == CAL_RUN && $past(sleep_active))
    else $error("active bit without a calibration in sleep");
  offset_upd_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(counter_offset_trim) |-> $past(offset_cal_active)
      && !offset_cal_active && $past(cal_timer) == CAL_LEN - 1)
    else $error("offset updated before full integration");
  sleep_entry_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(sleep_active) |-> $past(sleep_feature_enable) && $past(meas_valid))
    else $error("sleep entered without enable and measurement");
  bresp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
endmodule
`default_nettype wire

// ==== core/gcu_key_check.sv ====
// Unlock key sequence checker for the sealed access state
`timescale 1ns/100ps
`default_nettype none
module gcu_key_check
  import gcu_pkg::*;
#(
  parameter logic [31:0] KEY = UNLOCK_KEY_RST
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Command port words
  input  wire logic        cmd_valid,
  input  wire logic [15:0] cmd_word,
  input  wire logic        seal_req,
  // Lock state
  output logic             sealed
);
  gcu_key_e state;        // Sequence position
  gcu_key_e next_state;
  logic     next_sealed;

  // Next lock state; while sealed, every command write advances or restarts the pair
  always_comb begin
    next_state  = state;
    next_sealed = sealed;
    if (seal_req) begin
      next_sealed = 1'b1;
      next_state  = KEY_IDLE;
    end else if (cmd_valid && sealed) begin
      unique case (state)
        KEY_IDLE: begin
          // First word must match the low half of the key
          if (cmd_word == KEY[15:0]) begin
            next_state = KEY_GOT1;
          end
        end
        KEY_GOT1: begin
          // Any second write ends the attempt, good or bad
          next_state = KEY_IDLE;
          if (cmd_word == KEY[31:16]) begin
            next_sealed = 1'b0;
          end
        end
      endcase
    end
  end

  // Locked after reset so trims are protected from the start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state  <= KEY_IDLE;
      sealed <= 1'b1;
    end else begin
      state  <= next_state;
      sealed <= next_sealed;
    end
  end

  unlock_pair_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(sealed) |-> $past(cmd_valid) && $past(state) == KEY_GOT1
      && $past(cmd_word) == KEY[31:16])
    else $error("unlock without a matching key pair");
  bad_word_a: assert property (@(posedge aclk) disable iff (!aresetn)
    sealed && cmd_valid && !seal_req && cmd_word != KEY[15:0]
      && state == KEY_IDLE |=> state == KEY_IDLE && sealed)
    else $error("bad first word did not restart");
  seal_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    seal_req |=> sealed ##1 (sealed || $past(cmd_valid)))
    else $error("sealed bit dropped without a key");
endmodule
`default_nettype wire

// ==== core/gcu_pkg.sv ====
// Package: constants, register map and carriers of the gauge trim block
// Contract
// - Average current reads zero inside deadband
// - Signed board offset trims counter readings
// - Signed offset corrects reported temperature, no gain
// - Signed offset trims voltage, set in calibration
// - Sleep runs periodic 16 s counter offset calibration
// - Calibration-active bit high for whole calibration
// - Gain scales counter, delta cancels time-base error
// - Two key words back to back unlock
// - Sealed bit set while locked, cleared on unlock
// - Key is two identical words, default 0x8000
// - Sleep needs enable bit and current below 10
package gcu_pkg;
  // Clock and timing
  localparam int unsigned CLK_HZ         = 20_000_000;
  localparam int unsigned CAL_TIME_S     = 16;
  localparam int unsigned CAL_CYCLES     = CAL_TIME_S * CLK_HZ;
  localparam int unsigned CAL_GAP_S      = 20;
  localparam int unsigned CAL_GAP_CYCLES = CAL_GAP_S * CLK_HZ;
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_STAT  = 8'h04;
  localparam logic [7:0] ADDR_CMD   = 8'h08;
  localparam logic [7:0] ADDR_TRIM  = 8'h0C;
  localparam logic [7:0] ADDR_GAIN  = 8'h10;
  localparam logic [7:0] ADDR_DELTA = 8'h14;
  localparam logic [7:0] ADDR_COFS  = 8'h18;
  localparam logic [7:0] ADDR_CUR   = 8'h1C;
  localparam logic [7:0] ADDR_TEMP  = 8'h20;
  localparam logic [7:0] ADDR_VOLT  = 8'h24;
  // Control and status bit positions
  localparam int CTRL_SLEEP = 0;
  localparam int CTRL_CAL   = 1;
  localparam int CTRL_SEAL  = 2;
  localparam int STAT_SEAL  = 0;
  localparam int STAT_CAL_ACT = 1;
  localparam int STAT_SLEEP = 2;
  // Reset values and scaling
  localparam logic [31:0] UNLOCK_KEY_RST = 32'h8000_8000;
  localparam logic [7:0]  DEADBAND_RST   = 8'h05;
  localparam logic [7:0]  SLEEP_MA       = 8'h0A;
  localparam logic [15:0] GAIN_RST       = 16'h3C48;
  localparam logic [19:0] DELTA_RST      = 20'h889B3;
  localparam int          GAIN_FRAC      = 15;
  localparam int          DELTA_SHIFT    = 20;
  localparam int          CAL_AVG_SHIFT  = 4;
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Trim word, one byte per field
  typedef struct packed {
    logic        [7:0] deadband;
    logic signed [7:0] pack_v;
    logic signed [7:0] temp;
    logic signed [7:0] board;
  } gcu_trim_s;
  localparam logic [31:0] TRIM_RST = {DEADBAND_RST, 24'h000000};
  // Raw measurement set from the front end
  typedef struct packed {
    logic signed [15:0] cc;
    logic signed [15:0] temp;
    logic        [15:0] volt;
  } gcu_meas_s;
  // State machines
  typedef enum logic [1:0] {KEY_IDLE = 2'b01, KEY_GOT1 = 2'b10} gcu_key_e;
  typedef enum logic [1:0] {CAL_WAIT = 2'b01, CAL_RUN = 2'b10} gcu_cal_e;
endpackage

// ==== tb/gcu_host.sv ====
// Host model: AXI4-Lite master writing command words and registers
`timescale 1ns/100ps
`default_nettype none
module gcu_host (
  // Clock
  input  wire logic        aclk,
  // Write side
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  input  wire logic [1:0]  s_axi_bresp,
  // Read side
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  output logic [7:0]       s_axi_araddr,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp
);
  // Idle bus, whole words only
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'hF;
  end
  // One write at a time, so key words never interleave
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r, output bit ok);
    bit aw_t, w_t, b_t;
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wvalid  <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_bready  <= 1'b1;
    // Look mid-cycle, act on the next rising edge
    do begin
      @(negedge aclk);
      aw_t = s_axi_awvalid && s_axi_awready;
      w_t  = s_axi_wvalid && s_axi_wready;
      b_t  = s_axi_bvalid;
      r    = s_axi_bresp;
      @(posedge aclk);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
      if (b_t) s_axi_bready <= 1'b0;
      n++;
    end while (!b_t && n < 99);
    ok = b_t;
  endtask
  // One read; data taken at the edge where rvalid is seen
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r, output bit ok);
    bit a_t, r_t;
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= a;
    s_axi_rready  <= 1'b1;
    do begin
      @(negedge aclk);
      a_t = s_axi_arvalid && s_axi_arready;
      r_t = s_axi_rvalid;
      d   = s_axi_rdata;
      r   = s_axi_rresp;
      @(posedge aclk);
      if (a_t) s_axi_arvalid <= 1'b0;
      if (r_t) s_axi_rready <= 1'b0;
      n++;
    end while (!r_t && n < 99);
    ok = r_t;
  endtask
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Bench: unlock, trims, gain, deadband, sleep and calibration
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import gcu_pkg::*;
  // Clock, reset, front end
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        meas_valid = 1'b0;
  gcu_meas_s   meas = '0;
  // Bus between host model and block
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  // Reports
  logic        report_valid, offset_cal_active, sleep_active, sealed;
  logic [15:0] average_current_report, temp_report, volt_report, ve;
  int          fails = 0;
  int          n_checks = 0;
  int          cnt;
  // Short calibration counts keep the run brief
  gcu_core #(.CAL_LEN(50), .CAL_GAP(20)) dut (.*);
  gcu_host host (.*);
  always #25 aclk = ~aclk;
  // Count a compare, report a mismatch at once
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Counts, verdict, stop
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // A bus wait that ran out ends the run
  task automatic bus_ok(input bit ok);
    if (!ok) begin
      fails++;
      $display("[FAIL] %0t bus timeout", $time);
      give_verdict;
    end
  endtask
  // Register write with expected response
  task automatic w(input logic [7:0] a, input logic [31:0] d,
                   input logic [1:0] er);
    logic [1:0] r;
    bit ok;
    host.wr(a, d, r, ok);
    bus_ok(ok);
    chk(r, er);
  endtask
  // Register read; data ignored on an error response
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    bit ok;
    host.rd(a, d, r, ok);
    bus_ok(ok);
    chk({d & {32{er == RESP_OKAY}}, r}, {e, er});
  endtask
  // One sample at 25 C, 3000 mV; results due a cycle later
  task automatic m(input logic [15:0] cc, input logic [15:0] ec,
                   input bit es);
    @(posedge aclk);
    meas_valid <= 1'b1;
    meas       <= {cc, 16'd25, 16'd3000};
    @(posedge aclk);
    meas_valid <= 1'b0;
    @(negedge aclk);
    chk({sleep_active, report_valid, average_current_report, temp_report,
         volt_report}, {es, 1'b1, ec, 16'd23, ve});
  endtask
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_STAT, 32'h1, RESP_OKAY);
    w(ADDR_TRIM, 32'h0510_FE03, RESP_OKAY);
    rd(ADDR_TRIM, TRIM_RST, RESP_OKAY);
    // Bad first word, then a broken pair: stays locked
    w(ADDR_CMD, 32'h1234, RESP_OKAY);
    w(ADDR_CMD, 32'h8000, RESP_OKAY);
    w(ADDR_CMD, 32'h1234, RESP_OKAY);
    w(ADDR_CMD, 32'h8000, RESP_OKAY);
    rd(ADDR_STAT, 32'h1, RESP_OKAY);
    w(ADDR_CMD, 32'h8000, RESP_OKAY);
    rd(ADDR_STAT, 32'h0, RESP_OKAY);
    ve = 16'd3000;
    w(ADDR_TRIM, 32'h0510_FE03, RESP_OKAY);
    m(16'd1000, 16'd472, 1'b0);
    w(ADDR_CTRL, 32'h2, RESP_OKAY);
    w(ADDR_TRIM, 32'h0510_FE03, RESP_OKAY);
    ve = 16'd3016;
    m(-16'sd10, 16'h0000, 1'b0);
    m(-16'sd12, 16'hFFFB, 1'b0);
    w(ADDR_GAIN, 32'h4000, RESP_OKAY);
    m(16'd1000, 16'd501, 1'b0);
    w(ADDR_DELTA, 32'hC89B3, RESP_OKAY);
    m(16'd1000, 16'd626, 1'b0);
    w(ADDR_CTRL, 32'h1, RESP_OKAY);
    m(16'd1000, 16'd626, 1'b0);
    m(16'd0, 16'd0, 1'b1);
    // Stay in sleep on a small current; measure one calibration run
    cnt = 0;
    for (int i = 0; i < 300 && !(cnt > 0 && !offset_cal_active); i++) begin
      @(posedge aclk);
      meas_valid <= i[0];
      meas.cc    <= 16'd4;
      @(negedge aclk);
      if (offset_cal_active) cnt++;
    end
    @(posedge aclk) meas_valid <= 1'b0;
    chk(cnt, 50);
    rd(ADDR_STAT, 32'h4, RESP_OKAY);
    // Twenty-five samples of 4 settle the running average to 3
    rd(ADDR_COFS, 32'h3, RESP_OKAY);
    w(ADDR_CTRL, 32'h4, RESP_OKAY);
    rd(ADDR_STAT, 32'h1, RESP_OKAY);
    w(ADDR_TRIM, 32'h0, RESP_OKAY);
    rd(ADDR_TRIM, 32'h0510_FE03, RESP_OKAY);
    // Sealed: calibration mode and gain stay untouched
    w(ADDR_CTRL, 32'h2, RESP_OKAY);
    rd(ADDR_CTRL, 32'h0, RESP_OKAY);
    w(ADDR_GAIN, 32'h1234, RESP_OKAY);
    rd(ADDR_GAIN, 32'h4000, RESP_OKAY);
    rd(8'h40, 32'h0, RESP_SLVERR);
    w(8'h40, 32'h0, RESP_SLVERR);
    give_verdict;
  end
endmodule
`default_nettype wire
